/* File: dv/tmr_core_asserts.sv */
// checker: port level properties of the timer core
`timescale 1ns/1ns
module tmr_core_asserts
  import tmr_pkg::*;
(
  input wire logic       clk_i,         // clock
  input wire logic       sys_rst_i,     // sync reset
  input wire logic       ce_i,          // clock enable
  input wire logic [3:0] addr_i,        // offset
  input wire logic [7:0] wdata_i,       // write data
  input wire logic       wr_i,          // write strobe
  input wire logic       rd_i,          // read strobe
  input wire logic [7:0] rdata_o,       // read data
  input wire logic       pin_irq_req_i, // raw pin request
  input wire logic       pin_irq_o,     // gated pin request
  input wire logic       toggle_o,      // toggle level
  input wire logic       toggle_oe_n_o, // toggle owns pin
  input wire logic       pwm_o,         // pwm level
  input wire logic       pwm_oe_n_o,    // pwm owns pin
  input wire logic       ovf_irq_o,     // overflow irq
  input wire logic       irq_o          // event irq
);
  // ********
  // register mirrors
  // ********
  tmr_mode_t  mode_q; // mode copy
  logic       ien_q;  // overflow irq enable copy
  logic [2:0] een_q;  // event enable copy
  // mirrors move on the core's write edge, only when the core takes it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mode_q <= '0;
      ien_q  <= 1'b0;
      een_q  <= 3'h0;
    end else if (wr_i && ce_i) begin
      if (addr_i == TMR_OFF_MODE) mode_q <= tmr_mode_t'(wdata_i);
      if (addr_i == TMR_OFF_CTRL) ien_q <= wdata_i[TMR_CTRL_IEN_BIT];
      if (addr_i == TMR_OFF_IEN) een_q <= wdata_i[2:0];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // flag seen set, then enable written straight after
  sequence s_flag_read;
    rd_i && addr_i == TMR_OFF_CTRL;
  endsequence
  sequence s_enable_write;
    rdata_o[TMR_CTRL_IRQ_BIT] && wr_i && addr_i == TMR_OFF_CTRL && wdata_i[1:0] == 2'b11;
  endsequence
  a_mode_read_back: assert property (rd_i && addr_i == TMR_OFF_MODE |=> rdata_o == $past(mode_q))
    else $error("mode read back differs");
  a_wo_read_zero: assert property (
    rd_i && (addr_i == TMR_OFF_RELOAD || addr_i == TMR_OFF_ICLR || addr_i > 4'h6) |=> rdata_o == 8'h00)
    else $error("hidden register read not zero");
  a_stop_quiet: assert property (!mode_q.count_enable_bit |=> !toggle_o && !pwm_o)
    else $error("output moves while stopped");
  a_pin_irq_gate: assert property (pin_irq_o == ($past(pin_irq_req_i) && !$past(mode_q.clock_source_select)))
    else $error("pin request gating wrong");
  a_pwm_owns_pin: assert property (pwm_oe_n_o == !$past(mode_q.pwm_output_enable))
    else $error("pwm pin ownership wrong");
  a_toggle_owns_pin: assert property (
    toggle_oe_n_o == !($past(mode_q.toggle_output_enable) && !$past(mode_q.pwm_output_enable)))
    else $error("toggle pin ownership wrong");
  // an enabling ctrl write may raise the irq on the very next cycle
  a_ovf_irq_mask: assert property (
    !ien_q && !(wr_i && addr_i == TMR_OFF_CTRL && wdata_i[TMR_CTRL_IEN_BIT]) |=> !ovf_irq_o)
    else $error("overflow irq while disabled");
  a_flag_then_irq: assert property (s_flag_read ##1 s_enable_write |-> ##[1:2] ovf_irq_o)
    else $error("pending flag gave no irq");
  a_event_irq_mask: assert property (een_q == 3'h0 |=> !irq_o)
    else $error("event irq while masked");
endmodule : tmr_core_asserts

bind tmr_core tmr_core_asserts chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_irq_req_i(pin_irq_req_i),
  .pin_irq_o(pin_irq_o), .toggle_o(toggle_o), .toggle_oe_n_o(toggle_oe_n_o), .pwm_o(pwm_o),
  .pwm_oe_n_o(pwm_oe_n_o), .ovf_irq_o(ovf_irq_o), .irq_o(irq_o));

/* File: dv/tmr_core_test.sv */
// testbench: register level scenarios for the timer core
`timescale 1ns/1ns
module tmr_core_test;
  import tmr_pkg::*;
  logic       clk_i     = 1'b0; // bench clock
  logic       sys_rst_i = 1'b1; // sync reset
  logic       ce_i      = 1'b1; // running except in t_freeze
  logic [3:0] addr_i    = 4'h0; // offset
  logic [7:0] wdata_i   = 8'h00; // write data
  logic       wr_i      = 1'b0; // write strobe
  logic       rd_i      = 1'b0; // read strobe
  logic       ev_i      = 1'b1; // event pin, idles high
  logic       preq_i    = 1'b0; // raw pin request
  logic [7:0] rdata_o;          // read data
  logic       pin_o, tog_o, tog_oe_n_o, pwm_o, pwm_oe_n_o, ovf_o, irq_o; // outputs
  logic [7:0] mk [4]    = '{8'hff, 8'h3f, 8'h1f, 8'h0f}; // pwm masks
  int         errors    = 0;    // mismatches
  int         compares  = 0;    // comparisons
  // ********
  // clock, core
  // ********
  always #4 clk_i = ~clk_i;
  tmr_core dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .event_pin_i(ev_i), .pin_irq_req_i(preq_i),
    .pin_irq_o(pin_o), .toggle_o(tog_o), .toggle_oe_n_o(tog_oe_n_o), .pwm_o(pwm_o),
    .pwm_oe_n_o(pwm_oe_n_o), .ovf_irq_o(ovf_o), .irq_o(irq_o));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 q = rdata_o;
  endtask : rd
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] q;
    rd(a, q);
    chk(q, exp);
  endtask : rchk
  // read then write with no gap, so nothing can clear the flag between
  task automatic rd_wr(input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i    <= 1'b0;
    wr_i    <= 1'b1;
    wdata_i <= d;
    #1 q = rdata_o;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : rd_wr
  task automatic t_map;
    rchk(TMR_OFF_CTRL, 8'h00); // flag clear after reset
    wr(TMR_OFF_RELOAD, 8'h5a);
    rchk(TMR_OFF_RELOAD, 8'h00); // write only
    rchk(4'hf, 8'h00);
    wr(TMR_OFF_MODE, 8'h7a);
    rchk(TMR_OFF_MODE, 8'h7a);
    rchk(TMR_OFF_COUNT, 8'h00); // stopped
  endtask : t_map
  // read sits mid-way in the fifth tick period
  task automatic t_rate;
    int p;
    logic [7:0] q;
    for (int c = 0; c < 8; c++) begin
      p = 1 << (8 - c);
      wr(TMR_OFF_MODE, 8'h00); // stop first
      wr(TMR_OFF_COUNT, 8'h00);
      wr(TMR_OFF_MODE, {1'b1, c[2:0], 4'h0});
      repeat (p * 4 + p / 2 - 1) @(posedge clk_i);
      rd(TMR_OFF_COUNT, q);
      chk(q, 8'h04); // four ticks
    end
  endtask : t_rate
  task automatic t_tog(input logic ald, input int per);
    int n;
    logic [7:0] q;
    wr(TMR_OFF_MODE, 8'h00);
    wr(TMR_OFF_COUNT, 8'hfc);
    wr(TMR_OFF_RELOAD, 8'hf0);
    wr(TMR_OFF_MODE, {5'b11110, ald, 2'b10});
    for (n = 0; n < 600 && tog_o !== 1'b1; n++) @(posedge clk_i);
    for (n = 0; n < 600 && tog_o !== 1'b0; n++) @(posedge clk_i);
    chk(16'(n), 16'(per)); // half rate
    rd(TMR_OFF_COUNT, q);
    chk(8'(ald ? q >= 8'hf0 : q < 8'h10), 8'h01);
    rd(TMR_OFF_CTRL, q);
    chk(q & 8'h02, 8'h02);
    chk(8'(tog_oe_n_o), 8'h00); // toggle owns the pin
    wr(TMR_OFF_MODE, 8'h00);
    repeat (2) @(posedge clk_i);
    #1 chk(8'(tog_o), 8'h00);
    rchk(TMR_OFF_CTRL, 8'h02); // sticky
    wr(TMR_OFF_CTRL, 8'h00);
    rchk(TMR_OFF_CTRL, 8'h00);
  endtask : t_tog
  task automatic t_flag;
    logic [7:0] q;
    wr(TMR_OFF_ICLR, 8'h07);
    wr(TMR_OFF_COUNT, 8'hff);
    wr(TMR_OFF_CTRL, 8'h00); // irq masked before count write
    wr(TMR_OFF_COUNT, 8'h00);
    rchk(TMR_OFF_STAT, 8'h02);
    chk(8'(irq_o), 8'h00); // masked
    rd_wr(TMR_OFF_CTRL, 8'h03, q);
    chk(q & 8'h02, 8'h02); // set by the count write to 00
    repeat (2) @(posedge clk_i);
    #1 chk(8'(ovf_o), 8'h01);
    wr(TMR_OFF_CTRL, 8'h01);
    repeat (2) @(posedge clk_i);
    #1 chk(8'(ovf_o), 8'h00);
    wr(TMR_OFF_IEN, 8'h02);
    repeat (2) @(posedge clk_i);
    #1 chk(8'(irq_o), 8'h01);
    wr(TMR_OFF_ICLR, 8'h02);
    repeat (2) @(posedge clk_i);
    #1 chk(8'(irq_o), 8'h00);
    rchk(TMR_OFF_STAT, 8'h00);
    wr(TMR_OFF_IEN, 8'h00);
    wr(TMR_OFF_CTRL, 8'h00);
  endtask : t_flag
  // window of two pwm cycles makes the high count phase free
  task automatic t_pwm(input logic [1:0] sel, input int len, input int hi);
    int n;
    wr(TMR_OFF_MODE, 8'h00);
    wr(TMR_OFF_COUNT, 8'h00);
    wr(TMR_OFF_RELOAD, 8'h25);
    wr(TMR_OFF_MODE, {5'b11110, sel, 1'b1});
    repeat (8) @(posedge clk_i);
    chk(8'(pwm_oe_n_o), 8'h00);
    n = 0;
    repeat (len) begin
      @(posedge clk_i);
      n += int'(pwm_o === 1'b1);
    end
    chk(16'(n), 16'(hi)); // duty
  endtask : t_pwm
  task automatic t_ext;
    logic [7:0] q;
    wr(TMR_OFF_MODE, 8'h00);
    wr(TMR_OFF_COUNT, 8'h00);
    wr(TMR_OFF_MODE, 8'hf8);
    repeat (5) begin
      repeat (4) @(posedge clk_i);
      ev_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      ev_i <= 1'b1;
    end
    preq_i <= 1'b1;
    @(posedge clk_i);
    preq_i <= 1'b0;
    #1 chk(8'(pin_o), 8'h00);
    repeat (4) @(posedge clk_i);
    rd(TMR_OFF_COUNT, q);
    chk(q, 8'h05); // five falls
    wr(TMR_OFF_MODE, 8'h00);
    preq_i <= 1'b1;
    @(posedge clk_i);
    preq_i <= 1'b0;
    #1 chk(8'(pin_o), 8'h01);
  endtask : t_ext
  // enable low for 40 cycles must hold the count at four
  task automatic t_freeze;
    logic [7:0] q;
    wr(TMR_OFF_MODE, 8'h00);
    wr(TMR_OFF_COUNT, 8'h00);
    wr(TMR_OFF_MODE, 8'hf0);
    repeat (9) @(posedge clk_i);
    ce_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    ce_i <= 1'b1;
    rd(TMR_OFF_COUNT, q);
    chk(q, 8'h04); // no steps while frozen
    wr(TMR_OFF_MODE, 8'h00);
  endtask : t_freeze
  task automatic test_done;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_map;
    t_rate;
    t_tog(1'b1, 32);
    t_tog(1'b0, 512);
    t_flag;
    for (int s = 0; s < 4; s++) begin
      t_pwm(s[1:0], 4 * (int'(mk[s]) + 1), 4 * int'(mk[s] & 8'h25));
    end
    t_ext;
    t_freeze;
    test_done;
  end
  // watchdog well past the expected run length
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    test_done;
  end
endmodule : tmr_core_test

/* File: src/tmr_core.sv */
// top of the 8-bit up-counting timer with reload, toggle output, pwm and interrupts
//
// Behaviour
// (RULE1) clearing enable stops counter, toggle, pwm
// (RULE2) prescale select sits in mode bits 6..4
// (RULE3) source select: 0 internal, 1 event pin
// (RULE4) internal from cpu clock, external on fall
// (RULE5) pwm boundary 255/63/31/15 from reload,toggle bits
// (RULE6) software stops before reconfiguring, enables last
// (RULE7) software writes reload for reload or pwm
// (RULE8) flag sets when count leaves all-ones
// (RULE9) enable with flag pending interrupts next cycle
// (RULE10) software masks irq around run-time count writes
// (RULE11) software avoids 0xff outside pure pwm
// (RULE12) 8-bit counter increments once per event
// (RULE13) overflow keeps counting and requests interrupt
// (RULE14) overflow at ff to 00, 256 counts
// (RULE15) prescale 000 /256 down to 111 /2
// (RULE16) auto reload copies reload on overflow
// (RULE17) toggle output halves overflow rate, owns pin
// (RULE18) event pin irq silenced while source external
// (RULE19) irq flag stays until software writes zero
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module tmr_core (
  input  wire logic       clk_i,          // 125 mhz clock
  input  wire logic       sys_rst_i,      // sync reset, high
  input  wire logic       ce_i,           // clock enable, freezes state when low
  input  wire logic [3:0] addr_i,         // register offset
  input  wire logic [7:0] wdata_i,        // write data
  input  wire logic       wr_i,           // write strobe
  input  wire logic       rd_i,           // read strobe
  output logic      [7:0] rdata_o,        // read data, cycle after rd_i
  input  wire logic       event_pin_i,    // external event input pin (async)
  input  wire logic       pin_irq_req_i,  // raw pin edge request for the event pin
  output logic            pin_irq_o,      // gated pin interrupt request
  output logic            toggle_o,       // toggle output level
  output logic            toggle_oe_n_o,  // low while toggle owns the port pin
  output logic            pwm_o,          // pwm output level
  output logic            pwm_oe_n_o,     // low while pwm owns the port pin
  output logic            ovf_irq_o,      // overflow interrupt to cpu
  output logic            irq_o           // event status interrupt
);
  import tmr_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  tmr_mode_t             mode_q;          // timer mode register
  logic [7:0]            count_q;         // count register
  logic [7:0]            count_d;         // next count
  logic [7:0]            reload_q;        // reload register
  logic                  irq_en_q;        // overflow irq enable
  logic                  irq_flag_q;      // overflow irq flag
  logic [TMR_EV_W-1:0]   stat_q;          // sticky events
  logic [TMR_EV_W-1:0]   ien_q;           // event enables
  logic [TMR_EV_W-1:0]   ev_w;            // events this cycle
  logic [2:0]            pin_sync_q;      // event pin sync + edge stage
  logic                  tog_q;           // toggle flop
  tmr_bus_t              bus_w;           // bundled bus request
  logic                  tick_int_w;      // prescaler tick
  logic                  fall_w;          // event pin falling edge
  logic                  step_w;          // count event
  logic                  ovf_w;           // overflow this cycle
  logic                  wr_mode_w;       // write decodes
  logic                  wr_count_w;
  logic                  wr_reload_w;
  logic                  wr_ctrl_w;
  logic                  wr_ien_w;
  logic                  wr_iclr_w;
  logic                  wrap_w;          // count leaves all-ones
  logic [7:0]            pwm_mask_w;      // pwm cycle width mask
  logic [7:0]            pwm_pos_w;       // position within pwm cycle
  logic [7:0]            pwm_duty_w;      // duty threshold
  logic                  pwm_mode_w;      // pwm selected
  logic                  pwm_d;           // next pwm level
  logic [7:0]            rd_mux_w;        // read mux

  assign bus_w = '{wr: wr_i, rd: rd_i, addr: addr_i, data: wdata_i};

  // ****************************************
  // address decode
  // ****************************************
  assign wr_mode_w   = bus_w.wr && (bus_w.addr == TMR_OFF_MODE);
  assign wr_count_w  = bus_w.wr && (bus_w.addr == TMR_OFF_COUNT);
  assign wr_reload_w = bus_w.wr && (bus_w.addr == TMR_OFF_RELOAD);
  assign wr_ctrl_w   = bus_w.wr && (bus_w.addr == TMR_OFF_CTRL);
  assign wr_ien_w    = bus_w.wr && (bus_w.addr == TMR_OFF_IEN);
  assign wr_iclr_w   = bus_w.wr && (bus_w.addr == TMR_OFF_ICLR);

  // ****************************************
  // count sources
  // ****************************************
  tmr_prescale #(
    .PRE_W (TMR_PRE_W)
  ) u_pre (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .ce_i      (ce_i),
    .run_i     (mode_q.count_enable_bit && !mode_q.clock_source_select),
    .sel_i     (mode_q.prescale_select),                          // [RULE2]
    .tick_o    (tick_int_w)
  );

  // pin passes two flops; edge detect looks at stages 1 and 2 only
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_sync_q <= 3'h7;
    end else if (ce_i) begin
      pin_sync_q <= {pin_sync_q[1:0], event_pin_i};
    end
  end

  assign fall_w = pin_sync_q[2] && !pin_sync_q[1];                // [RULE4]

  // source select, gated by enable
  assign step_w = mode_q.count_enable_bit &&                      // [RULE1]
                  (mode_q.clock_source_select ? fall_w : tick_int_w); // [RULE3] [RULE4]

  // ****************************************
  // counter
  // ****************************************
  // overflow always at ff; wraps to 00 for 256 counts unless auto reload loads reload_q
  assign ovf_w      = step_w && (count_q == TMR_ALL_ONES);         // [RULE14]
  assign pwm_mode_w = mode_q.pwm_output_enable;

  // software write wins over counting in the same cycle
  always_comb begin
    count_d = count_q;
    if (wr_count_w) begin
      count_d = bus_w.data;
    end else if (ovf_w && mode_q.auto_reload_enable && !pwm_mode_w) begin
      count_d = reload_q;                                         // [RULE16]
    end else if (step_w) begin
      count_d = count_q + 8'h01;                                  // [RULE12] [RULE13]
    end
  end

  // any departure from all-ones, by counting or by write, raises flag
  assign wrap_w = (count_q == TMR_ALL_ONES) && (count_d != TMR_ALL_ONES); // [RULE8]

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      count_q <= TMR_RST_BYTE;
    end else if (ce_i) begin
      count_q <= count_d;
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mode_q   <= tmr_mode_t'(TMR_RST_BYTE);
      reload_q <= TMR_RST_BYTE;
      irq_en_q <= 1'b0;
    end else if (ce_i) begin
      if (wr_mode_w) begin
        mode_q <= tmr_mode_t'(bus_w.data);
      end
      if (wr_reload_w) begin
        reload_q <= bus_w.data;
      end
      if (wr_ctrl_w) begin
        irq_en_q <= bus_w.data[TMR_CTRL_IEN_BIT];
      end
    end
  end

  // ****************************************
  // overflow irq flag
  // ****************************************
  // set wins over a clear in the same cycle so no wrap is lost
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_flag_q <= 1'b0;
    end else if (ce_i) begin
      if (wrap_w) begin
        irq_flag_q <= 1'b1;                                       // [RULE8] [RULE13]
      end else if (wr_ctrl_w && !bus_w.data[TMR_CTRL_IRQ_BIT]) begin
        irq_flag_q <= 1'b0;                                       // [RULE19]
      end
    end
  end

  // ****************************************
  // toggle output
  // ****************************************
  // flop keeps its level while stopped; pin released when disabled
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tog_q <= 1'b0;
    end else if (ce_i && ovf_w && mode_q.toggle_output_enable && !pwm_mode_w) begin
      tog_q <= !tog_q;                                            // [RULE17]
    end
  end

  // ****************************************
  // pwm
  // ****************************************
  // boundary from reload,toggle bits: 00 ff, 01 3f, 10 1f, 11 0f
  assign pwm_mask_w = !mode_q.auto_reload_enable ?
                        (mode_q.toggle_output_enable ? 8'h3f : 8'hff) :
                        (mode_q.toggle_output_enable ? 8'h0f : 8'h1f); // [RULE5]
  assign pwm_pos_w  = count_q & pwm_mask_w;
  assign pwm_duty_w = reload_q & pwm_mask_w;
  // high while position below duty; stopped timer forces low
  assign pwm_d      = mode_q.count_enable_bit && pwm_mode_w && (pwm_pos_w < pwm_duty_w); // [RULE1] [RULE5]

  // ****************************************
  // event status and interrupts
  // ****************************************
  assign ev_w[TMR_EV_OVF]  = ovf_w;
  assign ev_w[TMR_EV_WRAP] = wrap_w;
  assign ev_w[TMR_EV_PWMC] = step_w && pwm_mode_w && (pwm_pos_w == pwm_mask_w);

  // set beats clear for each sticky bit
  genvar g;
  generate
    for (g = 0; g < TMR_EV_W; g++) begin : g_stat
      always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
          stat_q[g] <= 1'b0;
        end else if (ce_i) begin
          stat_q[g] <= ev_w[g] | (stat_q[g] & !(wr_iclr_w && bus_w.data[g]));
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ien_q <= '0;
    end else if (ce_i && wr_ien_w) begin
      ien_q <= bus_w.data[TMR_EV_W-1:0];
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  // reload and clear registers are write only and read zero
  always_comb begin
    rd_mux_w = 8'h00;
    unique case (bus_w.addr)
      TMR_OFF_MODE:  rd_mux_w = mode_q;
      TMR_OFF_COUNT: rd_mux_w = count_q;
      TMR_OFF_CTRL:  rd_mux_w = {6'h00, irq_flag_q, irq_en_q};
      TMR_OFF_STAT:  rd_mux_w = {5'h00, stat_q};
      TMR_OFF_IEN:   rd_mux_w = {5'h00, ien_q};
      default:       rd_mux_w = 8'h00;
    endcase
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_o       <= 8'h00;
      pin_irq_o     <= 1'b0;
      toggle_o      <= 1'b0;
      toggle_oe_n_o <= 1'b1;
      pwm_o         <= 1'b0;
      pwm_oe_n_o    <= 1'b1;
      ovf_irq_o     <= 1'b0;
      irq_o         <= 1'b0;
    end else if (ce_i) begin
      rdata_o       <= bus_w.rd ? rd_mux_w : 8'h00;
      pin_irq_o     <= pin_irq_req_i && !mode_q.clock_source_select; // [RULE18]
      toggle_o      <= tog_q && mode_q.count_enable_bit;           // [RULE1] [RULE17]
      toggle_oe_n_o <= !(mode_q.toggle_output_enable && !pwm_mode_w); // [RULE17]
      pwm_o         <= pwm_d;
      pwm_oe_n_o    <= !pwm_mode_w;
      // level from flag and enable: enabling onto a pending flag fires next cycle
      ovf_irq_o     <= (irq_flag_q || wrap_w) && (wr_ctrl_w ? bus_w.data[TMR_CTRL_IEN_BIT] : irq_en_q); // [RULE9]
      irq_o         <= |(stat_q & ien_q);
    end
  end
endmodule : tmr_core

/* File: src/tmr_pkg.sv */
// package: register map, field layout, reset values and timing constants of the 8-bit timer
package tmr_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [3:0] TMR_OFF_MODE   = 4'h0; // timer mode register
  localparam logic [3:0] TMR_OFF_COUNT  = 4'h1; // count register
  localparam logic [3:0] TMR_OFF_RELOAD = 4'h2; // reload register (write only)
  localparam logic [3:0] TMR_OFF_CTRL   = 4'h3; // irq enable / irq flag
  localparam logic [3:0] TMR_OFF_STAT   = 4'h4; // sticky event status (read only)
  localparam logic [3:0] TMR_OFF_IEN    = 4'h5; // event interrupt enable
  localparam logic [3:0] TMR_OFF_ICLR   = 4'h6; // event clear (write only)
  // ****************************************
  // field positions
  // ****************************************
  localparam int TMR_MODE_PWM_BIT  = 0;       // pwm output enable
  localparam int TMR_MODE_TOG_BIT  = 1;       // toggle output enable
  localparam int TMR_MODE_ALD_BIT  = 2;       // auto reload enable
  localparam int TMR_MODE_CKS_BIT  = 3;       // clock source select
  localparam int TMR_MODE_RATE_LO  = 4;       // prescale select low bit
  localparam int TMR_MODE_ENB_BIT  = 7;       // count enable
  localparam int TMR_CTRL_IEN_BIT  = 0;       // overflow irq enable
  localparam int TMR_CTRL_IRQ_BIT  = 1;       // overflow irq flag
  localparam int TMR_EV_OVF        = 0;       // event: overflow
  localparam int TMR_EV_WRAP       = 1;       // event: count left all-ones
  localparam int TMR_EV_PWMC       = 2;       // event: pwm cycle end
  localparam int TMR_EV_W          = 3;       // number of status events
  // ****************************************
  // reset values and constants
  // ****************************************
  localparam logic [7:0] TMR_RST_BYTE  = 8'h00; // all registers reset to zero
  localparam logic [7:0] TMR_ALL_ONES  = 8'hff; // overflow source value
  localparam int         TMR_PRE_W     = 8;     // prescaler width, divide by 256 max

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic       count_enable_bit;    // bit 7
    logic [2:0] prescale_select;     // bits 6..4
    logic       clock_source_select; // bit 3
    logic       auto_reload_enable;  // bit 2
    logic       toggle_output_enable;// bit 1
    logic       pwm_output_enable;   // bit 0
  } tmr_mode_t;

  typedef struct packed {
    logic       wr;   // write strobe
    logic       rd;   // read strobe
    logic [3:0] addr; // register offset
    logic [7:0] data; // write data
  } tmr_bus_t;
endpackage : tmr_pkg

/* File: src/tmr_prescale.sv */
// prescaler: divider, cleared while stopped, producing one-cycle ticks of fcpu/2..fcpu/256
`timescale 1ns/1ns
module tmr_prescale #(
  parameter int PRE_W = tmr_pkg::TMR_PRE_W  // divider width
) (
  input  wire logic       clk_i,     // 125 mhz clock
  input  wire logic       sys_rst_i, // sync reset, high
  input  wire logic       ce_i,      // clock enable
  input  wire logic       run_i,     // counting allowed
  input  wire logic [2:0] sel_i,     // prescale select code
  output logic            tick_o     // one-cycle count tick
);
  import tmr_pkg::*;

  logic [PRE_W-1:0] div_q;  // divider counter
  logic [PRE_W-1:0] mask_w; // low bits that must be all ones
  logic [3:0]       len_w;  // number of bits to compare

  // code 000 -> 8 bits (/256), 111 -> 1 bit (/2)
  assign len_w  = 4'h8 - {1'b0, sel_i};                           // [RULE15]
  assign mask_w = PRE_W'((9'h001 << len_w) - 9'h001);

  // ****************************************
  // divider
  // ****************************************
  // held in reset while stopped so the first tick is a full period
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      div_q  <= '0;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      div_q  <= run_i ? div_q + PRE_W'(1) : '0;
      tick_o <= run_i && ((div_q & mask_w) == mask_w);            // [RULE15]
    end
  end
endmodule : tmr_prescale
